// ---- rtc_core.sv ----
// calendar clock core with alarm, square wave, countdown and serial slave
`timescale 1ns/1ps
module rtc_core import rtc_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h51, // arbitrary value
	parameter int OSC_PER_SEC = OSC_HZ
) (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	// oscillator time base
	input wire logic osc_clk,
	// two-wire serial bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// open-drain interrupt / clock pin
	input wire logic int_in,
	output logic int_out,
	output logic int_oe
);

	localparam int PULSE_CYC = PULSE_MS * OSC_PER_SEC / MS_PER_S;

	//--------------------------------------------------------------------
	// helpers
	//--------------------------------------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] >= 4'h9)
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		else
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
			(yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
		if (mon == MONTH_FEB)
			days_in_month = leap ? 8'h29 : 8'h28;
		else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
			days_in_month = 8'h30;
		else
			days_in_month = 8'h31;
	endfunction

	//--------------------------------------------------------------------
	// oscillator domain
	//--------------------------------------------------------------------
	logic orst_meta_ff, orst_ff;
	logic [4:0] cfg_meta_ff, cfg_ff;
	logic [DIV_W-1:0] div_ff;
	logic [$clog2(OSC_PER_SEC)-1:0] sec_div_ff;
	logic sec_tgl_ff, f4k_tgl_ff, f64_tgl_ff, wave_ff, pulse_ff;
	logic [4:0] wave_cfg;
	logic [7:0] ctrl2_ff, ctrl3_ff;

	// rate and enable are quasi-static; per-bit sync is enough
	assign wave_cfg = {ctrl2_ff[C2_WAVE_EN], ctrl3_ff[3:0]};

	always_ff @(posedge osc_clk) begin
		orst_meta_ff <= sys_rst;
		orst_ff <= orst_meta_ff;
		cfg_meta_ff <= wave_cfg;
		cfg_ff <= cfg_meta_ff;
	end

	always_ff @(posedge osc_clk) begin
		if (orst_ff) begin
			div_ff <= '0;
			sec_div_ff <= '0;
			sec_tgl_ff <= 1'b0;
			f4k_tgl_ff <= 1'b0;
			f64_tgl_ff <= 1'b0;
			pulse_ff <= 1'b0;
		end else begin
			div_ff <= div_ff + 1'b1;
			if (div_ff[2:0] == 3'h7)
				f4k_tgl_ff <= ~f4k_tgl_ff;
			if (div_ff[8:0] == 9'h1ff)
				f64_tgl_ff <= ~f64_tgl_ff;
			if (32'(sec_div_ff) == OSC_PER_SEC - 1) begin
				sec_div_ff <= '0;
				sec_tgl_ff <= ~sec_tgl_ff;
			end else begin
				sec_div_ff <= sec_div_ff + 1'b1;
			end
			pulse_ff <= 32'(sec_div_ff) < PULSE_CYC;
		end
	end

	// wave level as seen on the pin: 1 releases, 0 pulls low
	always_ff @(posedge osc_clk) begin
		if (orst_ff || !cfg_ff[4] || cfg_ff[3:0] == RATE_OFF)
			wave_ff <= 1'b1;
		else if (cfg_ff[3:0] == RATE_1S)
			wave_ff <= 32'(sec_div_ff) >= OSC_PER_SEC / 2;
		else
			wave_ff <= div_ff[WAVE_TAP[cfg_ff[3:0]]];
	end

	//--------------------------------------------------------------------
	// crossings into the system clock
	//--------------------------------------------------------------------
	logic [6:0] x_meta_ff, x_sync_ff, x_prev_ff;
	logic sec_tick, f4k_tick, f64_tick, pulse_s, wave_s;
	logic scl_s, sda_s, scl_p, sda_p;

	always_ff @(posedge clk) begin
		x_meta_ff <= {scl_in, sda_in, pulse_ff, wave_ff, sec_tgl_ff, f4k_tgl_ff, f64_tgl_ff};
		x_sync_ff <= x_meta_ff;
		x_prev_ff <= x_sync_ff;
	end

	assign {scl_s, sda_s, pulse_s, wave_s} = x_sync_ff[6:3];
	assign {scl_p, sda_p} = x_prev_ff[6:5];
	assign sec_tick = x_sync_ff[2] ^ x_prev_ff[2];
	assign f4k_tick = x_sync_ff[1] ^ x_prev_ff[1];
	assign f64_tick = x_sync_ff[0] ^ x_prev_ff[0];

	//--------------------------------------------------------------------
	// serial slave
	//--------------------------------------------------------------------
	rtc_bus_e st_ff;
	logic [3:0] cnt_ff;
	logic [7:0] shift_ff, tx_ff, rd_data;
	logic [4:0] ptr_ff;
	logic oe_ff, rw_ff, nack_ff;
	logic wr_stb_ff;
	logic [4:0] wr_addr_ff;
	logic [7:0] wr_data_ff;
	logic bus_start, bus_stop, scl_rise, scl_fall;

	assign bus_start = scl_s && scl_p && sda_p && !sda_s;
	assign bus_stop = scl_s && scl_p && !sda_p && sda_s;
	assign scl_rise = scl_s && !scl_p;
	assign scl_fall = !scl_s && scl_p;
	assign sda_out = 1'b0;
	assign sda_oe = oe_ff;

	always_ff @(posedge clk) begin
		wr_stb_ff <= 1'b0;
		if (sys_rst) begin
			st_ff <= RTC_ST_IDLE;
			cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			ptr_ff <= 5'h00;
			oe_ff <= 1'b0;
			rw_ff <= 1'b0;
			nack_ff <= 1'b0;
			wr_addr_ff <= 5'h00;
			wr_data_ff <= 8'h00;
		end else if (bus_start) begin
			st_ff <= RTC_ST_ADDR;
			cnt_ff <= 4'h0;
			oe_ff <= 1'b0;
		end else if (bus_stop) begin
			st_ff <= RTC_ST_IDLE;
			oe_ff <= 1'b0;
		end else if (scl_rise) begin
			if (st_ff == RTC_ST_ADDR || st_ff == RTC_ST_REG || st_ff == RTC_ST_WDATA) begin
				shift_ff <= {shift_ff[6:0], sda_s};
				cnt_ff <= cnt_ff + 4'h1;
			end else if (st_ff == RTC_ST_RACK) begin
				nack_ff <= sda_s;
			end
		end else if (scl_fall) begin
			unique case (st_ff)
				RTC_ST_IDLE: ;
				RTC_ST_ADDR: if (cnt_ff == 4'h8) begin
					if (shift_ff[7:1] == DEV_ADDR) begin
						st_ff <= RTC_ST_ACK_ADDR;
						rw_ff <= shift_ff[0];
						oe_ff <= 1'b1;
					end else begin
						st_ff <= RTC_ST_IDLE;
					end
				end
				RTC_ST_ACK_ADDR, RTC_ST_RACK: begin
					if (st_ff == RTC_ST_RACK && nack_ff) begin
						st_ff <= RTC_ST_IDLE;
						oe_ff <= 1'b0;
					end else if (rw_ff) begin
						st_ff <= RTC_ST_RDATA;
						tx_ff <= {rd_data[6:0], 1'b0};
						oe_ff <= !rd_data[7];
						ptr_ff <= ptr_ff + 5'h01;
						cnt_ff <= 4'h0;
					end else begin
						st_ff <= RTC_ST_REG;
						oe_ff <= 1'b0;
						cnt_ff <= 4'h0;
					end
				end
				RTC_ST_REG: if (cnt_ff == 4'h8) begin
					ptr_ff <= shift_ff[4:0];
					st_ff <= RTC_ST_ACK_REG;
					oe_ff <= 1'b1;
				end
				RTC_ST_WDATA: if (cnt_ff == 4'h8) begin
					wr_stb_ff <= 1'b1;
					wr_addr_ff <= ptr_ff;
					wr_data_ff <= shift_ff;
					ptr_ff <= ptr_ff + 5'h01;
					st_ff <= RTC_ST_ACK_WDATA;
					oe_ff <= 1'b1;
				end
				RTC_ST_ACK_REG, RTC_ST_ACK_WDATA: begin
					st_ff <= RTC_ST_WDATA;
					oe_ff <= 1'b0;
					cnt_ff <= 4'h0;
				end
				RTC_ST_RDATA: begin
					if (cnt_ff == 4'h7) begin
						st_ff <= RTC_ST_RACK;
						oe_ff <= 1'b0;
					end else begin
						oe_ff <= !tx_ff[7];
						tx_ff <= {tx_ff[6:0], 1'b0};
						cnt_ff <= cnt_ff + 4'h1;
					end
				end
				default: st_ff <= RTC_ST_IDLE;
			endcase
		end
	end

	function automatic logic wr_hit(input logic stb, input logic [4:0] a, input logic [4:0] r);
		wr_hit = stb && (a == r);
	endfunction

	//--------------------------------------------------------------------
	// timekeeping
	//--------------------------------------------------------------------
	logic [7:0] sec_ff, min_ff, hour_ff, wday_ff, date_ff, month_ff, year_ff;
	logic [7:0] nxt_sec, nxt_min, nxt_hour, nxt_wday, nxt_date, nxt_month, nxt_year;
	logic sec_pend_ff, tick_apply;

	// a second that lands mid-transfer waits, so a full time load is not torn
	assign tick_apply = sec_pend_ff && st_ff == RTC_ST_IDLE;

	always_ff @(posedge clk) begin
		if (sys_rst)
			sec_pend_ff <= 1'b0;
		else if (sec_tick)
			sec_pend_ff <= 1'b1;
		else if (tick_apply)
			sec_pend_ff <= 1'b0;
	end

	always_comb begin
		logic [7:0] h;
		h = 8'h00;
		nxt_sec = sec_ff;
		nxt_min = min_ff;
		nxt_hour = hour_ff;
		nxt_wday = wday_ff;
		nxt_date = date_ff;
		nxt_month = month_ff;
		nxt_year = year_ff;
		if (tick_apply) begin
			nxt_sec = bcd_inc(sec_ff);
			if (sec_ff >= SEC_MAX) begin
				nxt_sec = 8'h00;
				nxt_min = bcd_inc(min_ff);
				if (min_ff >= SEC_MAX) begin
					nxt_min = 8'h00;
					if (hour_ff[HOUR_FMT_BIT]) begin
						h = bcd_inc({2'b00, hour_ff[5:0]});
						if (hour_ff[5:0] >= HOUR24_MAX)
							h = 8'h00;
						nxt_hour = {1'b1, h[6:0]};
					end else begin
						h = bcd_inc({3'b000, hour_ff[4:0]});
						nxt_hour = {hour_ff[7:5], h[4:0]};
						if (hour_ff[4:0] == HOUR12_MAX)
							nxt_hour = {hour_ff[7:5], 5'h01};
						else if (hour_ff[4:0] == HOUR12_NOON)
							nxt_hour[HOUR_PM_BIT] = !hour_ff[HOUR_PM_BIT];
					end
					if ((hour_ff[HOUR_FMT_BIT] && hour_ff[5:0] >= HOUR24_MAX) ||
						(!hour_ff[HOUR_FMT_BIT] && hour_ff[HOUR_PM_BIT] &&
						hour_ff[4:0] == HOUR12_NOON)) begin
						nxt_wday = (wday_ff[2:0] >= WDAY_MAX) ? 8'h00 : wday_ff + 8'h01;
						nxt_date = bcd_inc(date_ff);
						if (date_ff >= days_in_month(month_ff, year_ff)) begin
							nxt_date = 8'h01;
							nxt_month = bcd_inc(month_ff);
							if (month_ff >= MONTH_MAX) begin
								nxt_month = 8'h01;
								nxt_year = (year_ff >= YEAR_MAX) ? 8'h00 : bcd_inc(year_ff);
							end
						end
					end
				end
			end
		end
	end

	// no reset on purpose: time survives a reset
	always_ff @(posedge clk) begin
		sec_ff <= wr_hit(wr_stb_ff, wr_addr_ff, REG_SEC) ? wr_data_ff : nxt_sec;
		min_ff <= wr_hit(wr_stb_ff, wr_addr_ff, REG_MIN) ? wr_data_ff : nxt_min;
		hour_ff <= wr_hit(wr_stb_ff, wr_addr_ff, REG_HOUR) ? wr_data_ff : nxt_hour;
		wday_ff <= wr_hit(wr_stb_ff, wr_addr_ff, REG_WDAY) ? wr_data_ff : nxt_wday;
		date_ff <= wr_hit(wr_stb_ff, wr_addr_ff, REG_DATE) ? wr_data_ff : nxt_date;
		month_ff <= wr_hit(wr_stb_ff, wr_addr_ff, REG_MONTH) ? wr_data_ff : nxt_month;
		year_ff <= wr_hit(wr_stb_ff, wr_addr_ff, REG_YEAR) ? wr_data_ff : nxt_year;
	end

	//--------------------------------------------------------------------
	// configuration registers and user memory
	//--------------------------------------------------------------------
	logic [6:0][7:0] alm_ff;
	logic [7:0] alm_en_ff, ctrl1_ff, trim_ff;
	logic [7:0] ram_ff [RAM_BYTES];

	for (genvar i = 0; i < 7; i++) begin : g_alarm
		always_ff @(posedge clk) begin
			if (sys_rst)
				alm_ff[i] <= RST_ALARM;
			else if (wr_hit(wr_stb_ff, wr_addr_ff, REG_ALM_SEC + 5'(i)))
				alm_ff[i] <= wr_data_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			alm_en_ff <= RST_CTRL;
			ctrl1_ff <= RST_CTRL;
			ctrl2_ff <= RST_CTRL;
			ctrl3_ff <= RST_CTRL;
			trim_ff <= RST_CTRL;
		end else if (wr_stb_ff) begin
			if (wr_addr_ff == REG_ALM_EN)
				alm_en_ff <= {1'b0, wr_data_ff[6:0]};
			if (wr_addr_ff == REG_CTRL1)
				ctrl1_ff <= wr_data_ff;
			if (wr_addr_ff == REG_CTRL2)
				ctrl2_ff <= wr_data_ff;
			if (wr_addr_ff == REG_CTRL3)
				ctrl3_ff <= wr_data_ff;
			if (wr_addr_ff == REG_TRIM)
				trim_ff <= wr_data_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (wr_stb_ff && wr_addr_ff >= REG_RAM_LO)
			ram_ff[4'(wr_addr_ff - REG_RAM_LO)] <= wr_data_ff;
	end

	//--------------------------------------------------------------------
	// alarm comparator
	//--------------------------------------------------------------------
	logic [6:0] fld_hit;
	logic alarm_match, match_prev_ff, alarm_flag_ff;

	always_comb begin
		fld_hit[EN_SEC] = sec_ff == alm_ff[0];
		fld_hit[EN_MIN] = min_ff == alm_ff[1];
		fld_hit[EN_HOUR] = hour_ff[6:0] == alm_ff[2][6:0];
		fld_hit[EN_WDAY] = alm_en_ff[EN_DATE] || alm_ff[3][wday_ff[2:0]];
		fld_hit[EN_DATE] = date_ff == alm_ff[4];
		fld_hit[EN_MONTH] = month_ff == alm_ff[5];
		fld_hit[EN_YEAR] = year_ff == alm_ff[6];
	end

	assign alarm_match = |alm_en_ff[6:0] && &(fld_hit | ~alm_en_ff[6:0]);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			match_prev_ff <= 1'b0;
			alarm_flag_ff <= 1'b0;
		end else begin
			match_prev_ff <= alarm_match;
			if (alarm_match && !match_prev_ff)
				alarm_flag_ff <= 1'b1;
			else if (wr_hit(wr_stb_ff, wr_addr_ff, REG_ALM_EN))
				alarm_flag_ff <= 1'b0;
			else if (wr_hit(wr_stb_ff, wr_addr_ff, REG_CTRL1))
				alarm_flag_ff <= alarm_flag_ff && wr_data_ff[C1_ALM_FLAG];
		end
	end

	//--------------------------------------------------------------------
	// countdown timer
	//--------------------------------------------------------------------
	logic [7:0] cd_ff;
	logic [5:0] min_div_ff;
	logic cd_flag_ff, cd_tick;

	always_ff @(posedge clk) begin
		if (sys_rst)
			min_div_ff <= 6'h00;
		else if (sec_tick)
			min_div_ff <= (min_div_ff == SECS_PER_MIN - 6'h01) ? 6'h00 : min_div_ff + 6'h01;
	end

	always_comb begin
		unique case (ctrl3_ff[C3_SRC_HI:C3_SRC_LO])
			CD_4096: cd_tick = f4k_tick;
			CD_64: cd_tick = f64_tick;
			CD_1: cd_tick = sec_tick;
			CD_MINUTE: cd_tick = sec_tick && min_div_ff == SECS_PER_MIN - 6'h01;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cd_ff <= RST_CTRL;
			cd_flag_ff <= 1'b0;
		end else begin
			if (wr_hit(wr_stb_ff, wr_addr_ff, REG_CDOWN))
				cd_ff <= wr_data_ff;
			else if (ctrl2_ff[C2_CD_EN] && cd_tick && cd_ff != 8'h00)
				cd_ff <= cd_ff - 8'h01;
			if (ctrl2_ff[C2_CD_EN] && cd_tick && cd_ff == 8'h01)
				cd_flag_ff <= 1'b1;
			else if (wr_hit(wr_stb_ff, wr_addr_ff, REG_CTRL1))
				cd_flag_ff <= cd_flag_ff && wr_data_ff[C1_CD_FLAG];
		end
	end

	//--------------------------------------------------------------------
	// read mux
	//--------------------------------------------------------------------
	always_comb begin
		rd_data = 8'h00;
		if (ptr_ff >= REG_RAM_LO)
			rd_data = ram_ff[4'(ptr_ff - REG_RAM_LO)];
		else if (ptr_ff >= REG_ALM_SEC && ptr_ff <= REG_ALM_YEAR)
			rd_data = alm_ff[3'(ptr_ff - REG_ALM_SEC)];
		else begin
			unique case (ptr_ff)
				REG_SEC: rd_data = sec_ff;
				REG_MIN: rd_data = min_ff;
				REG_HOUR: rd_data = hour_ff;
				REG_WDAY: rd_data = wday_ff;
				REG_DATE: rd_data = date_ff;
				REG_MONTH: rd_data = month_ff;
				REG_YEAR: rd_data = year_ff;
				REG_ALM_EN: rd_data = alm_en_ff;
				REG_CTRL1: begin
					rd_data = ctrl1_ff & 8'hce;
					rd_data[C1_ALM_FLAG] = alarm_flag_ff;
					rd_data[C1_CD_FLAG] = cd_flag_ff;
				end
				REG_CTRL2: rd_data = ctrl2_ff;
				REG_CTRL3: rd_data = ctrl3_ff;
				REG_TRIM: rd_data = trim_ff;
				REG_CDOWN: rd_data = cd_ff;
				default: rd_data = 8'h00;
			endcase
		end
	end

	//--------------------------------------------------------------------
	// interrupt pin
	//--------------------------------------------------------------------
	logic int_oe_ff, fast_ff;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			int_oe_ff <= 1'b0;
			fast_ff <= 1'b0;
		end else begin
			fast_ff <= ctrl2_ff[C2_SEL_HI:C2_SEL_LO] == SEL_WAVE &&
				ctrl2_ff[C2_WAVE_EN] && ctrl3_ff[3:0] == RATE_32K;
			unique case (ctrl2_ff[C2_SEL_HI:C2_SEL_LO])
				SEL_OFF: int_oe_ff <= 1'b0;
				SEL_ALARM: int_oe_ff <= ctrl2_ff[C2_ALM_EN] && alarm_flag_ff &&
					(!ctrl2_ff[C2_REPEAT] || pulse_s);
				SEL_WAVE: int_oe_ff <= !wave_s;
				SEL_CDOWN: int_oe_ff <= ctrl2_ff[C2_CD_EN] && cd_flag_ff;
			endcase
		end
	end

	// full-rate output cannot be resampled, so the oscillator drives the pin
	assign int_oe = fast_ff ? !osc_clk : int_oe_ff;
	assign int_out = 1'b0;

endmodule

// ---- rtc_pkg.sv ----
// constants, field positions and bus states for the real-time clock core
//--------------------------------------------------------------------------
// Notes on behaviour
// - hour format bit one selects 24-hour counting
// - time registers keep contents through reset
// - weekday counts cyclically zero through six
// - two-digit BCD years with correct leap Februaries
// - alarm and countdown flags set, stay until cleared
// - two-bit selector picks interrupt pin source
// - alarm interrupt enable gates alarm pin output
// - match-enable bits: year down to second
// - alarm flag sets when enabled fields first match
// - date enable overrides weekday comparison
// - weekday alarm is a Sunday-to-Saturday mask
// - writing match-enable register clears alarm flag
// - repeat bit: steady low or periodic pulses
// - each repeat pulse is low 250 ms
// - square wave enable and sixteen-entry rate field
// - countdown source: 4096, 64, 1, 1/60 Hz
// - countdown decrements when enabled, flag at zero
//--------------------------------------------------------------------------
package rtc_pkg;

	// register offsets
	localparam logic [4:0] REG_SEC = 5'h00;
	localparam logic [4:0] REG_MIN = 5'h01;
	localparam logic [4:0] REG_HOUR = 5'h02;
	localparam logic [4:0] REG_WDAY = 5'h03;
	localparam logic [4:0] REG_DATE = 5'h04;
	localparam logic [4:0] REG_MONTH = 5'h05;
	localparam logic [4:0] REG_YEAR = 5'h06;
	localparam logic [4:0] REG_ALM_SEC = 5'h07;
	localparam logic [4:0] REG_ALM_MIN = 5'h08;
	localparam logic [4:0] REG_ALM_HOUR = 5'h09;
	localparam logic [4:0] REG_ALM_WDAY = 5'h0a;
	localparam logic [4:0] REG_ALM_DATE = 5'h0b;
	localparam logic [4:0] REG_ALM_MONTH = 5'h0c;
	localparam logic [4:0] REG_ALM_YEAR = 5'h0d;
	localparam logic [4:0] REG_ALM_EN = 5'h0e;
	localparam logic [4:0] REG_CTRL1 = 5'h0f;
	localparam logic [4:0] REG_CTRL2 = 5'h10;
	localparam logic [4:0] REG_CTRL3 = 5'h11;
	localparam logic [4:0] REG_TRIM = 5'h12;
	localparam logic [4:0] REG_CDOWN = 5'h13;
	localparam logic [4:0] REG_RAM_LO = 5'h14;
	localparam int RAM_BYTES = 12;

	// reset values
	localparam logic [7:0] RST_ALARM = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;

	// field positions
	localparam int HOUR_FMT_BIT = 7;
	localparam int HOUR_PM_BIT = 5;
	localparam int EN_YEAR = 6;
	localparam int EN_MONTH = 5;
	localparam int EN_DATE = 4;
	localparam int EN_WDAY = 3;
	localparam int EN_HOUR = 2;
	localparam int EN_MIN = 1;
	localparam int EN_SEC = 0;
	localparam int C1_ALM_FLAG = 5;
	localparam int C1_CD_FLAG = 4;
	localparam int C2_REPEAT = 6;
	localparam int C2_SEL_HI = 5;
	localparam int C2_SEL_LO = 4;
	localparam int C2_CD_EN = 2;
	localparam int C2_ALM_EN = 1;
	localparam int C2_WAVE_EN = 0;
	localparam int C3_SRC_HI = 5;
	localparam int C3_SRC_LO = 4;

	// pin source and countdown source codes
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_ALARM = 2'h1;
	localparam logic [1:0] SEL_WAVE = 2'h2;
	localparam logic [1:0] SEL_CDOWN = 2'h3;
	localparam logic [1:0] CD_4096 = 2'h0;
	localparam logic [1:0] CD_64 = 2'h1;
	localparam logic [1:0] CD_1 = 2'h2;
	localparam logic [1:0] CD_MINUTE = 2'h3;

	// square wave rates: divider tap per rate code
	localparam logic [3:0] RATE_OFF = 4'h0;
	localparam logic [3:0] RATE_32K = 4'h1;
	localparam logic [3:0] RATE_1S = 4'hf;
	localparam logic [15:0][4:0] WAVE_TAP = {5'h0e, 5'h12, 5'h11, 5'h10, 5'h0f, 5'h0e,
		5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08, 5'h04, 5'h02, 5'h00, 5'h00};
	localparam int DIV_W = 19;

	// BCD limits, and the binary count of seconds per minute
	localparam logic [7:0] SEC_MAX = 8'h59;
	localparam logic [5:0] HOUR24_MAX = 6'h23;
	localparam logic [4:0] HOUR12_MAX = 5'h12;
	localparam logic [4:0] HOUR12_NOON = 5'h11;
	localparam logic [2:0] WDAY_MAX = 3'h6;
	localparam logic [7:0] MONTH_MAX = 8'h12;
	localparam logic [7:0] MONTH_FEB = 8'h02;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [5:0] SECS_PER_MIN = 6'h3c;

	// timing
	localparam int OSC_HZ = 32768;
	localparam int PULSE_MS = 250;
	localparam int MS_PER_S = 1000;

	typedef enum logic [3:0] {
		RTC_ST_IDLE = 4'h0,
		RTC_ST_ADDR = 4'h1,
		RTC_ST_ACK_ADDR = 4'h2,
		RTC_ST_REG = 4'h3,
		RTC_ST_ACK_REG = 4'h4,
		RTC_ST_WDATA = 4'h5,
		RTC_ST_ACK_WDATA = 4'h6,
		RTC_ST_RDATA = 4'h7,
		RTC_ST_RACK = 4'h8
	} rtc_bus_e;

endpackage

// ---- rtc_core_properties.sv ----
// port-level timing checks for the clock core
`timescale 1ns/1ps
module rtc_core_properties import rtc_pkg::*; (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic osc_clk,
	// serial bus
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// interrupt pin
	input wire logic int_in,
	input wire logic int_out,
	input wire logic int_oe
);
	//----------------------------------------
	// assertions
	//----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	a_int_only_pulls: assert property (int_out == 1'b0)
		else $error("int pin driven high");
	a_sda_only_pulls: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	a_sda_high_stable: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
		else $error("data changed while bus clock high");
	a_ack_rise_low: assert property ($rose(sda_oe) |-> !scl_in ##1 !scl_in)
		else $error("data pulled outside clock low");
	a_ack_fall_low: assert property ($fell(sda_oe) |-> !scl_in)
		else $error("data released outside clock low");
	a_ack_held: assert property ($rose(sda_oe) |=> sda_oe [*4])
		else $error("data pull too short");
	a_release_gap: assert property ($fell(sda_oe) |=> !sda_oe [*4])
		else $error("data release too short");
	// control registers come out of reset with the pin source off
	a_reset_quiet: assert property ($fell(sys_rst) |-> (!sda_oe && !int_oe) ##1 !int_oe [*3])
		else $error("pins active after reset");
endmodule
bind rtc_core rtc_core_properties u_props (.clk(clk), .sys_rst(sys_rst),
	.osc_clk(osc_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .int_in(int_in), .int_out(int_out), .int_oe(int_oe));

// ---- rtc_host.sv ----
// two-wire bus master model standing in for the host controller
`timescale 1ns/1ps
module rtc_host import rtc_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h51 // arbitrary value
) (
	// bus
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	//----------------------------------------
	// bus cycles
	//----------------------------------------
	logic [7:0] buf_q [8];
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic half();
		repeat (5) @(negedge clk);
	endtask
	// data changes only in the low half, sampled mid high half
	task automatic bit_io(input logic b, output logic r);
		sda_pull = !b;
		half();
		scl = 1'b1;
		half();
		r = sda;
		half();
		scl = 1'b0;
		half();
	endtask
	task automatic start();
		sda_pull = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_pull = 1'b1;
		half();
		scl = 1'b0;
		half();
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_pull = 1'b0;
		half();
	endtask
	task automatic byte_tx(input logic [7:0] d, output logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ok = (r === 1'b0);
	endtask
	// all bytes go in one transfer; time fields must never be split
	task automatic write_regs(input logic [7:0] ptr, input int n, output logic ok);
		logic a;
		start();
		byte_tx({DEV_ADDR, 1'b0}, ok);
		byte_tx(ptr, a);
		ok &= a;
		for (int i = 0; i < n; i++) begin
			byte_tx(buf_q[i], a);
			ok &= a;
		end
		stop();
	endtask
	task automatic read_regs(input logic [7:0] ptr, input int n, output logic ok);
		logic a;
		start();
		byte_tx({DEV_ADDR, 1'b0}, ok);
		byte_tx(ptr, a);
		ok &= a;
		start();
		byte_tx({DEV_ADDR, 1'b1}, a);
		ok &= a;
		for (int i = 0; i < n; i++) begin
			for (int j = 7; j >= 0; j--) bit_io(1'b1, buf_q[i][j]);
			bit_io(i == n - 1, a);
		end
		stop();
	endtask
endmodule

// ---- tb_rtc_core.sv ----
// register-level test of the clock core through the serial bus
`timescale 1ns/1ps
module tb_rtc_core import rtc_pkg::*; ();
	//----------------------------------------
	// bench
	//----------------------------------------
	localparam int SEC_CLK = 2458; // one time-base second in clk cycles
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic osc_clk = 1'b0;
	logic scl, sda_pull, sda_out, sda_oe, int_out, int_oe;
	wire logic sda = !(sda_pull || sda_oe);
	wire logic int_in = !int_oe;
	int miscompares = 0;
	int tests_run = 0;
	logic [7:0] tset [3][7] = '{'{8'h59, 8'h59, 8'ha3, 8'h06, 8'h28, 8'h02, 8'h00},
		'{8'h59, 8'h59, 8'h31, 8'h02, 8'h28, 8'h02, 8'h01},
		'{8'h00, 8'h10, 8'h90, 8'h01, 8'h15, 8'h06, 8'h24}};
	logic [7:0] texp [2][6] = '{'{8'h00, 8'h00, 8'h00, 8'h29, 8'h02, 8'h00},
		'{8'h00, 8'h12, 8'h03, 8'h01, 8'h03, 8'h01}};
	logic [7:0] rst_addr [11] = '{8'h07, 8'h08, 8'h09, 8'h0b, 8'h0d, 8'h0e, 8'h0f,
		8'h10, 8'h11, 8'h12, 8'h13};
	always #10 clk = ~clk;
	initial begin
		#7;
		forever #24 osc_clk = ~osc_clk;
	end
	rtc_core #(.OSC_PER_SEC(1024)) dut (.clk(clk), .sys_rst(sys_rst), .osc_clk(osc_clk),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .int_in(int_in),
		.int_out(int_out), .int_oe(int_oe));
	rtc_host host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
		logic ok;
		host.buf_q[0] = val;
		host.write_regs(ptr, 1, ok);
		check("write ack", 8'h01, {7'h00, ok});
	endtask
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp, input logic [7:0] msk);
		logic ok;
		host.read_regs(ptr, 1, ok);
		check("read ack", 8'h01, {7'h00, ok});
		check($sformatf("reg %h", ptr), exp, host.buf_q[0] & msk);
	endtask
	task automatic wait_pin(input logic v, input int lim);
		int k;
		k = 0;
		while (int_oe !== v && k < lim) begin
			@(negedge clk);
			k++;
		end
		check("int pin", {7'h00, v}, {7'h00, int_oe});
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		finish_test();
	end
	initial begin
		logic ok;
		int n;
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		foreach (rst_addr[i]) rd(rst_addr[i], 8'h00, 8'hff);
		// hour format bit masked before comparing the hour
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 7; i++) host.buf_q[i] = tset[c][i];
			host.write_regs(8'h00, 7, ok);
			check("write ack", 8'h01, {7'h00, ok});
			repeat (SEC_CLK * 3 / 2) @(negedge clk);
			host.read_regs(8'h01, 6, ok);
			for (int i = 0; i < 6; i++) check("calendar", texp[c][i], host.buf_q[i] & (i == 1 ? 8'h7f : 8'hff));
		end
		host.buf_q = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h15, 8'h00, 8'h00, 8'h19};
		host.write_regs(8'h07, 8, ok);
		wr(8'h10, 8'h52);
		for (int i = 0; i < 7; i++) host.buf_q[i] = tset[2][i];
		host.write_regs(8'h00, 7, ok);
		wait_pin(1'b1, SEC_CLK * 4);
		wait_pin(1'b0, SEC_CLK);
		wait_pin(1'b1, SEC_CLK);
		n = 0;
		while (int_oe === 1'b1 && n < SEC_CLK) begin
			@(negedge clk);
			n++;
		end
		check("pulse width", 8'h01, {7'h00, n > 610 && n < 618});
		rd(8'h0f, 8'h20, 8'h20);
		// single-event mode: pin must hold low whatever the pulse phase
		wr(8'h10, 8'h12);
		check("int pin", 8'h01, {7'h00, int_oe});
		wr(8'h0e, 8'h19);
		rd(8'h0f, 8'h00, 8'h20);
		check("int pin", 8'h00, {7'h00, int_oe});
		wr(8'h11, 8'h10);
		wr(8'h10, 8'h34);
		wr(8'h13, 8'h03);
		rd(8'h0f, 8'h00, 8'h10);
		repeat (3000) @(negedge clk);
		rd(8'h0f, 8'h10, 8'h10);
		rd(8'h13, 8'h00, 8'hff);
		check("int pin", 8'h01, {7'h00, int_oe});
		wr(8'h0f, 8'h00);
		check("int pin", 8'h00, {7'h00, int_oe});
		wr(8'h11, 8'h01);
		wr(8'h10, 8'h21);
		@(posedge osc_clk);
		#2;
		check("wave", 8'h00, {7'h00, int_oe});
		@(negedge osc_clk);
		#2;
		check("wave", 8'h01, {7'h00, int_oe});
		wr(8'h10, 8'h00);
		check("int pin", 8'h00, {7'h00, int_oe});
		finish_test();
	end
endmodule
